// ===== rtl/fan_smooth_pkg.sv
package fan_smooth_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] SMOOTH_IDX = 10'h063;
   localparam logic [9:0] SLOT_CFG_IDX = 10'h010;
   localparam logic [9:0] LOCK_IDX = 10'h040;
   localparam logic [9:0] DRIVE_STAT_IDX = 10'h060;
   localparam logic [11:0] SMOOTH_ADDR = 12'h18c;
   localparam logic [11:0] SLOT_CFG_ADDR = 12'h040;
   localparam logic [11:0] LOCK_ADDR = 12'h100;
   localparam logic [11:0] DRIVE_STAT_ADDR = 12'h180;
   // field positions in the smoothing, slot-config and lock registers
   localparam int LOCAL_RATE_LSB = 0;
   localparam int LOCAL_ON_BIT = 3;
   localparam int REMOTE_TWO_RATE_LSB = 4;
   localparam int REMOTE_TWO_ON_BIT = 7;
   localparam int SLOT_LONG_BIT = 7;
   localparam int LOCK_BIT = 0;
   // reset values
   localparam logic [7:0] SMOOTH_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing: one slot is a full-scale ramp at one step per slot over 255 steps
   localparam int CLK_MHZ = 40;
   localparam int FULL_SCALE_STEPS = 255;
   localparam int RAMP_SHORT_MS = 37500;
   localparam int RAMP_LONG_MS = 52200;
   localparam int SLOT_SHORT_US = (RAMP_SHORT_MS * 1000) / FULL_SCALE_STEPS;
   localparam int SLOT_LONG_US = (RAMP_LONG_MS * 1000) / FULL_SCALE_STEPS;
   localparam int SLOT_SHORT_CYCLES = SLOT_SHORT_US * CLK_MHZ;
   localparam int SLOT_LONG_CYCLES = SLOT_LONG_US * CLK_MHZ;

   // duty steps per slot for a 3-bit rate code
   function automatic logic [7:0] steps_per_slot(input logic [2:0] code);
      logic [7:0] s;
      s = 8'h01;
      case (code)
         3'h0: s = 8'h01;
         3'h1: s = 8'h02;
         3'h2: s = 8'h03;
         3'h3: s = 8'h04;
         3'h4: s = 8'h08;
         3'h5: s = 8'h0c;
         3'h6: s = 8'h18;
         default: s = 8'h30;
      endcase
      return s;
   endfunction
endpackage

// ===== rtl/duty_slew.sv
`timescale 1ns/1ps
module duty_slew #(
   parameter int DUTY_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic smooth_on,
   input wire logic [2:0] rate_code,
   input wire logic slot_tick,
   // duty path
   input wire logic [DUTY_W-1:0] target,
   output logic [DUTY_W-1:0] duty_q
);
   logic [DUTY_W-1:0] duty_d;
   logic [DUTY_W-1:0] step;
   logic [DUTY_W-1:0] gap;

   generate
      if (DUTY_W < 6) begin : g_bad_width
         $error("duty_slew needs DUTY_W of at least 6 to hold a step of 48");
      end
   endgenerate

   always_comb begin
      step = DUTY_W'(fan_smooth_pkg::steps_per_slot(rate_code));
      gap = (target > duty_q) ? target - duty_q : duty_q - target;
      duty_d = duty_q;
      if (!smooth_on) begin
         duty_d = target;
      end else if (slot_tick) begin
         // last step lands exactly on the target, never overshoots
         if (gap <= step) begin
            duty_d = target;
         end else if (target > duty_q) begin
            duty_d = duty_q + step;
         end else begin
            duty_d = duty_q - step;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         duty_q <= fan_smooth_pkg::DUTY_RESET;
      end else begin
         duty_q <= duty_d;
      end
   end
endmodule

// ===== rtl/fan_pwm_slew_smoothing.sv
// Summary of operation
// - bits 2..0 pick the local channel's most duty steps per slot: 1, 2, 3, 4, 8, 12, 24 or 48.
// - with smoothing on, the duty walks toward a new target no faster than the programmed rate.
// - with the slot-speed bit clear, a full 0 to 100 percent ramp takes 37.5 s at code 0 down to 0.8 s at code 7.
// - with the slot-speed bit set, the slot is longer and the same ramp takes 52.2 s down to 1.1 s.
// - bit 3 set turns on smoothing for the local channel.
// - bits 6..4 pick the remote two channel's rate with the same encoding and times.
// - bit 7 set turns on smoothing for the remote two channel.
// - once the lock bit is set, writes leave the smoothing register unchanged.
// - the smoothing register sits at index 0x63 and comes out of reset as zero.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module fan_pwm_slew_smoothing #(
   parameter int SLOT_SHORT_CYCLES = fan_smooth_pkg::SLOT_SHORT_CYCLES,
   parameter int SLOT_LONG_CYCLES = fan_smooth_pkg::SLOT_LONG_CYCLES
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // axi4-lite write address
   input wire logic [11:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // axi4-lite write data
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // axi4-lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read address
   input wire logic [11:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   // axi4-lite read data
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // targets from the automatic control loop
   input wire logic [7:0] LOCAL_TARGET,
   input wire logic [7:0] REMOTE_TWO_TARGET,
   // slew-limited duty to the pwm stage
   output logic [7:0] LOCAL_FAN_DRIVE_OUTPUT,
   output logic [7:0] REMOTE_TWO_FAN_DRIVE_OUTPUT
);
   localparam int CNT_W = 32;

   generate
      if (SLOT_SHORT_CYCLES < 1 || SLOT_LONG_CYCLES < SLOT_SHORT_CYCLES) begin : g_bad_slot
         $error("slot counts must be positive and the long slot no shorter than the short one");
      end
   endgenerate

   // register state
   logic [7:0] smooth_q;
   logic [7:0] smooth_d;
   logic slot_long_q;
   logic slot_long_d;
   logic lock_q;
   logic lock_d;

   // write channel state
   logic aw_full_q;
   logic aw_full_d;
   logic w_full_q;
   logic w_full_d;
   logic [11:0] waddr_q;
   logic [11:0] waddr_d;
   logic [31:0] wdata_q;
   logic [31:0] wdata_d;
   logic [3:0] wstrb_q;
   logic [3:0] wstrb_d;
   logic awready_q;
   logic awready_d;
   logic wready_q;
   logic wready_d;
   logic bvalid_q;
   logic bvalid_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;

   // read channel state
   logic arready_q;
   logic arready_d;
   logic rvalid_q;
   logic rvalid_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;

   // slot timer
   logic [CNT_W-1:0] slot_cnt_q;
   logic [CNT_W-1:0] slot_cnt_d;
   logic slot_tick_q;
   logic slot_tick_d;

   logic [7:0] local_duty;
   logic [7:0] remote_two_duty;

   function automatic logic known_addr(input logic [11:0] a);
      logic hit;
      hit = 1'b0;
      if (a == fan_smooth_pkg::SMOOTH_ADDR) begin
         hit = 1'b1;
      end else if (a == fan_smooth_pkg::SLOT_CFG_ADDR) begin
         hit = 1'b1;
      end else if (a == fan_smooth_pkg::LOCK_ADDR) begin
         hit = 1'b1;
      end else if (a == fan_smooth_pkg::DRIVE_STAT_ADDR) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // write path and register updates
   always_comb begin
      logic do_write;
      do_write = 1'b0;
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      smooth_d = smooth_q;
      slot_long_d = slot_long_q;
      lock_d = lock_q;
      if (AWVALID && awready_q) begin
         aw_full_d = 1'b1;
         waddr_d = AWADDR;
      end
      if (WVALID && wready_q) begin
         w_full_d = 1'b1;
         wdata_d = WDATA;
         wstrb_d = WSTRB;
      end
      if (bvalid_q && BREADY) begin
         bvalid_d = 1'b0;
      end
      if (aw_full_q && w_full_q && !bvalid_q) begin
         do_write = 1'b1;
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = known_addr(waddr_q) ? fan_smooth_pkg::RESP_OKAY : fan_smooth_pkg::RESP_SLVERR;
      end
      if (do_write && wstrb_q[0]) begin
         if (waddr_q == fan_smooth_pkg::SMOOTH_ADDR) begin
            // locked writes still answer okay; the data is dropped
            if (!lock_q) begin
               smooth_d = wdata_q[7:0];
            end
         end else if (waddr_q == fan_smooth_pkg::SLOT_CFG_ADDR) begin
            slot_long_d = wdata_q[fan_smooth_pkg::SLOT_LONG_BIT];
         end else if (waddr_q == fan_smooth_pkg::LOCK_ADDR) begin
            // lock only sets; reset is the one way out
            lock_d = lock_q | wdata_q[fan_smooth_pkg::LOCK_BIT];
         end
      end
      // readys stay low until the response is taken: one write in flight
      awready_d = !aw_full_d && !bvalid_d;
      wready_d = !w_full_d && !bvalid_d;
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         waddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= fan_smooth_pkg::RESP_OKAY;
         smooth_q <= fan_smooth_pkg::SMOOTH_RESET;
         slot_long_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         smooth_q <= smooth_d;
         slot_long_q <= slot_long_d;
         lock_q <= lock_d;
      end
   end

   // read path
   always_comb begin
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && RREADY) begin
         rvalid_d = 1'b0;
      end
      if (ARVALID && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = fan_smooth_pkg::RESP_OKAY;
         rdata_d = 32'h0000_0000;
         if (ARADDR == fan_smooth_pkg::SMOOTH_ADDR) begin
            rdata_d[7:0] = smooth_q;
         end else if (ARADDR == fan_smooth_pkg::SLOT_CFG_ADDR) begin
            rdata_d[fan_smooth_pkg::SLOT_LONG_BIT] = slot_long_q;
         end else if (ARADDR == fan_smooth_pkg::LOCK_ADDR) begin
            rdata_d[fan_smooth_pkg::LOCK_BIT] = lock_q;
         end else if (ARADDR == fan_smooth_pkg::DRIVE_STAT_ADDR) begin
            rdata_d[7:0] = local_duty;
            rdata_d[15:8] = remote_two_duty;
         end else begin
            rresp_d = fan_smooth_pkg::RESP_SLVERR;
         end
      end
      arready_d = !rvalid_d;
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= fan_smooth_pkg::RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // shared slot timer; length follows the slot-speed bit
   // one counter for both channels keeps their steps in phase
   always_comb begin
      logic [CNT_W-1:0] limit;
      limit = slot_long_q ? CNT_W'(SLOT_LONG_CYCLES - 1) : CNT_W'(SLOT_SHORT_CYCLES - 1);
      slot_tick_d = 1'b0;
      slot_cnt_d = slot_cnt_q + 1'b1;
      // >= so a switch to the short slot mid-count cannot overrun
      if (slot_cnt_q >= limit) begin
         slot_cnt_d = '0;
         slot_tick_d = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         slot_cnt_q <= '0;
         slot_tick_q <= 1'b0;
      end else begin
         slot_cnt_q <= slot_cnt_d;
         slot_tick_q <= slot_tick_d;
      end
   end

   duty_slew #(
      .DUTY_W(8)
   ) u_local_slew (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .smooth_on(smooth_q[fan_smooth_pkg::LOCAL_ON_BIT]),
      .rate_code(smooth_q[fan_smooth_pkg::LOCAL_RATE_LSB +: 3]),
      .slot_tick(slot_tick_q),
      .target(LOCAL_TARGET),
      .duty_q(local_duty)
   );

   duty_slew #(
      .DUTY_W(8)
   ) u_remote_two_slew (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .smooth_on(smooth_q[fan_smooth_pkg::REMOTE_TWO_ON_BIT]),
      .rate_code(smooth_q[fan_smooth_pkg::REMOTE_TWO_RATE_LSB +: 3]),
      .slot_tick(slot_tick_q),
      .target(REMOTE_TWO_TARGET),
      .duty_q(remote_two_duty)
   );

   assign AWREADY = awready_q;
   assign WREADY = wready_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;
   assign LOCAL_FAN_DRIVE_OUTPUT = local_duty;
   assign REMOTE_TWO_FAN_DRIVE_OUTPUT = remote_two_duty;
endmodule

// ===== verif/fan_smooth_assertions.sv
`timescale 1ns/1ps
module fan_smooth_assertions (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // register bus
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [1:0] BRESP,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic [31:0] RDATA,
   // duty path
   input wire logic [7:0] LOCAL_TARGET,
   input wire logic [7:0] REMOTE_TWO_TARGET,
   input wire logic [7:0] LOCAL_FAN_DRIVE_OUTPUT,
   input wire logic [7:0] REMOTE_TWO_FAN_DRIVE_OUTPUT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   sequence s_wr_taken;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence s_wr_answer;
      !AWREADY && !WREADY ##1 BVALID;
   endsequence
   chk_wr_latency: assert property (s_wr_taken |=> s_wr_answer)
      else $error("write response late");
   chk_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   chk_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   chk_rd_latency: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
      else $error("read answer late");
   chk_upper_zero: assert property (RVALID |-> RDATA[31:16] == 16'h0)
      else $error("read upper bits set");
   // reset itself is the trigger here, so no disable
   chk_reset_zero: assert property (disable iff (1'b0) !RESETN |=>
      LOCAL_FAN_DRIVE_OUTPUT == 8'h00 && !BVALID)
      else $error("outputs not cleared by reset");
   chk_local_up: assert property (LOCAL_FAN_DRIVE_OUTPUT > $past(LOCAL_FAN_DRIVE_OUTPUT) |->
      LOCAL_FAN_DRIVE_OUTPUT <= $past(LOCAL_TARGET))
      else $error("local drive overshoots target");
   chk_remote_down: assert property (REMOTE_TWO_FAN_DRIVE_OUTPUT < $past(REMOTE_TWO_FAN_DRIVE_OUTPUT) |->
      REMOTE_TWO_FAN_DRIVE_OUTPUT >= $past(REMOTE_TWO_TARGET))
      else $error("remote two drive undershoots target");
endmodule
bind fan_pwm_slew_smoothing fan_smooth_assertions i_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
   .LOCAL_TARGET(LOCAL_TARGET), .REMOTE_TWO_TARGET(REMOTE_TWO_TARGET), .LOCAL_FAN_DRIVE_OUTPUT(LOCAL_FAN_DRIVE_OUTPUT),
   .REMOTE_TWO_FAN_DRIVE_OUTPUT(REMOTE_TWO_FAN_DRIVE_OUTPUT));

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
   logic SYS_CLK = 1'b0;
   logic RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [11:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic [7:0] LOCAL_TARGET, REMOTE_TWO_TARGET, LOCAL_FAN_DRIVE_OUTPUT, REMOTE_TWO_FAN_DRIVE_OUTPUT;
   logic [7:0] st [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
   int errors = 0;
   int n_checks = 0;
   int n;
   always #12.5 SYS_CLK = ~SYS_CLK;
   // short slots of 20 and 28 cycles keep each step inside the 60-cycle wait limit
   fan_pwm_slew_smoothing #(.SLOT_SHORT_CYCLES(20), .SLOT_LONG_CYCLES(28)) i_fan_pwm_slew_smoothing (
      .SYS_CLK(SYS_CLK), .RESETN(RESETN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY), .LOCAL_TARGET(LOCAL_TARGET), .REMOTE_TWO_TARGET(REMOTE_TWO_TARGET),
      .LOCAL_FAN_DRIVE_OUTPUT(LOCAL_FAN_DRIVE_OUTPUT), .REMOTE_TWO_FAN_DRIVE_OUTPUT(REMOTE_TWO_FAN_DRIVE_OUTPUT));
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask
   task guard(input int k);
      if (k >= 60) begin
         $display("FAIL wait expected done seen timeout");
         errors++;
         test_done();
      end
   endtask
   // sampling at the falling edge avoids racing the design's own updates
   task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ta, tw, hb;
      logic [1:0] r;
      int k;
      @(posedge SYS_CLK);
      AWADDR <= a;
      WDATA <= {24'h0, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      k = 0;
      do begin
         @(negedge SYS_CLK);
         ta = AWREADY;
         tw = WREADY;
         hb = BVALID;
         r = BRESP;
         @(posedge SYS_CLK);
         if (ta) AWVALID <= 1'b0;
         if (tw) WVALID <= 1'b0;
         k++;
      end while (!hb && k < 60);
      BREADY <= 1'b0;
      guard(k);
      chk("bresp", er, r);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, hb;
      logic [31:0] d;
      logic [1:0] r;
      int k;
      @(posedge SYS_CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      k = 0;
      do begin
         @(negedge SYS_CLK);
         ta = ARREADY;
         hb = RVALID;
         d = RDATA;
         r = RRESP;
         @(posedge SYS_CLK);
         if (ta) ARVALID <= 1'b0;
         k++;
      end while (!hb && k < 60);
      RREADY <= 1'b0;
      guard(k);
      chk("rdata", ed, d);
      chk("rresp", er, r);
   endtask
   task wait_change(output int k);
      logic [7:0] v;
      v = LOCAL_FAN_DRIVE_OUTPUT;
      k = 0;
      do begin
         @(negedge SYS_CLK);
         k++;
      end while (LOCAL_FAN_DRIVE_OUTPUT === v && k < 60);
      guard(k);
   endtask
   initial begin
      RESETN = 1'b0;
      AWVALID = 1'b0;
      WVALID = 1'b0;
      BREADY = 1'b0;
      ARVALID = 1'b0;
      RREADY = 1'b0;
      AWADDR = 12'h000;
      ARADDR = 12'h000;
      WDATA = 32'h0;
      WSTRB = 4'hf;
      LOCAL_TARGET = 8'hff;
      REMOTE_TWO_TARGET = 8'hff;
      repeat (8) @(posedge SYS_CLK);
      RESETN <= 1'b1;
      rd(fan_smooth_pkg::SMOOTH_ADDR, 32'h0, fan_smooth_pkg::RESP_OKAY);
      rd(12'hffc, 32'h0, fan_smooth_pkg::RESP_SLVERR);
      wr(12'hffc, 8'h11, fan_smooth_pkg::RESP_SLVERR);
      $display("test reset_map done");
      for (int c = 0; c < 8; c++) begin
         wr(fan_smooth_pkg::SMOOTH_ADDR, 8'h00, fan_smooth_pkg::RESP_OKAY);
         repeat (2) @(negedge SYS_CLK);
         chk("local follow", 8'hff, LOCAL_FAN_DRIVE_OUTPUT);
         chk("remote follow", 8'hff, REMOTE_TWO_FAN_DRIVE_OUTPUT);
         rd(fan_smooth_pkg::DRIVE_STAT_ADDR, 32'h0000_ffff, fan_smooth_pkg::RESP_OKAY);
         LOCAL_TARGET <= 8'h00;
         REMOTE_TWO_TARGET <= 8'h00;
         wr(fan_smooth_pkg::SLOT_CFG_ADDR, {c[0], 7'h0}, fan_smooth_pkg::RESP_OKAY);
         wr(fan_smooth_pkg::SMOOTH_ADDR, {1'b1, 3'(7 - c), 1'b1, 3'(c)}, fan_smooth_pkg::RESP_OKAY);
         LOCAL_TARGET <= 8'hff;
         REMOTE_TWO_TARGET <= 8'hff;
         wait_change(n);
         chk("local step", st[c], LOCAL_FAN_DRIVE_OUTPUT);
         chk("remote step", st[7 - c], REMOTE_TWO_FAN_DRIVE_OUTPUT);
         wait_change(n);
         chk("slot", c[0] ? 32'd28 : 32'd20, n);
         chk("local second", 2 * st[c], LOCAL_FAN_DRIVE_OUTPUT);
      end
      $display("test slew done");
      rd(fan_smooth_pkg::SLOT_CFG_ADDR, 32'h80, fan_smooth_pkg::RESP_OKAY);
      WSTRB <= 4'he;
      wr(fan_smooth_pkg::SMOOTH_ADDR, 8'h00, fan_smooth_pkg::RESP_OKAY);
      WSTRB <= 4'hf;
      rd(fan_smooth_pkg::SMOOTH_ADDR, 32'h8f, fan_smooth_pkg::RESP_OKAY);
      wr(fan_smooth_pkg::SMOOTH_ADDR, 8'h5a, fan_smooth_pkg::RESP_OKAY);
      wr(fan_smooth_pkg::LOCK_ADDR, 8'h01, fan_smooth_pkg::RESP_OKAY);
      wr(fan_smooth_pkg::SMOOTH_ADDR, 8'ha5, fan_smooth_pkg::RESP_OKAY);
      rd(fan_smooth_pkg::SMOOTH_ADDR, 32'h5a, fan_smooth_pkg::RESP_OKAY);
      rd(fan_smooth_pkg::LOCK_ADDR, 32'h1, fan_smooth_pkg::RESP_OKAY);
      $display("test lock done");
      test_done();
   end
endmodule
